/* urx_pkg.sv */
`default_nettype none
package urx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB side)
  // ----------------------------------------------------------------
  localparam logic [7:0] URX_ADDR_MODE_ONE = 8'h00;  // channel_a_mode_reg_one
  localparam logic [7:0] URX_ADDR_MODE_TWO = 8'h04;  // channel_a_mode_reg_two
  localparam logic [7:0] URX_ADDR_STATUS   = 8'h08;  // channel_a_status_reg
  localparam logic [7:0] URX_ADDR_COMMAND  = 8'h0C;  // channel_a_command_reg
  localparam logic [7:0] URX_ADDR_RX_BUF   = 8'h10;  // receive buffer
  localparam logic [7:0] URX_ADDR_OUT_CTRL = 8'h14;  // output line control

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int URX_ST_RDY  = 0;
  localparam int URX_ST_FULL = 1;
  localparam int URX_ST_OVR  = 4;
  localparam int URX_ST_PAR  = 5;
  localparam int URX_ST_FRM  = 6;
  localparam int URX_ST_BRK  = 7;
  localparam int URX_M1_FLOW    = 7;
  localparam int URX_M1_IRQ_SEL = 6;
  localparam int URX_M1_BLOCK   = 5;
  localparam int URX_M1_PAR_ODD = 2;
  localparam int URX_OC_RTS_ON  = 0;
  localparam int URX_OC_RTS_OFF = 1;

  // Parity field (mode one bits 4:3)
  localparam logic [1:0] URX_PAR_WITH  = 2'h0;
  localparam logic [1:0] URX_PAR_FORCE = 2'h1;
  localparam logic [1:0] URX_PAR_NONE  = 2'h2;
  localparam logic [1:0] URX_PAR_MDROP = 2'h3;

  // Command register fields
  localparam logic [1:0] URX_RX_ENABLE   = 2'h1;
  localparam logic [1:0] URX_RX_DISABLE  = 2'h2;
  localparam logic [3:0] URX_CMD_RST_RX  = 4'h2;
  localparam logic [3:0] URX_CMD_RST_ERR = 4'h4;

  // ----------------------------------------------------------------
  // Reset values, FIFO entry layout, timing
  // ----------------------------------------------------------------
  localparam logic [7:0] URX_MODE_ONE_RST = 8'h00;
  localparam logic [7:0] URX_MODE_TWO_RST = 8'h00;
  localparam int URX_ENT_W   = 11;
  localparam int URX_ENT_PAR = 8;
  localparam int URX_ENT_FRM = 9;
  localparam int URX_ENT_BRK = 10;
  localparam int URX_FIFO_DEPTH_DEF = 8;
  localparam int URX_BIT_CLKS_DEF   = 16;

  // Channel operating modes (mode two bits 7:6)
  typedef enum logic [1:0] {
    URX_NORMAL = 2'b00,
    URX_ECHO   = 2'b01,
    URX_LOCAL  = 2'b10,
    URX_REMOTE = 2'b11
  } urx_chan_mode_t;

  // Receive framing states
  typedef enum logic [2:0] {
    URX_IDLE  = 3'b000,
    URX_START = 3'b001,
    URX_DATA  = 3'b010,
    URX_PARB  = 3'b011,
    URX_STOP  = 3'b100,
    URX_BRKW  = 3'b101
  } urx_rx_state_t;

endpackage

`default_nettype wire

/* urx_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module urx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Control
  input  wire logic                     push,
  input  wire logic                     pop,
  input  wire logic                     flush,
  input  wire logic [WIDTH-1:0]         din,
  // State
  output logic      [WIDTH-1:0]         dout,
  output logic                          full,
  output logic                          empty,
  output logic      [$clog2(DEPTH):0]   count
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Push ignored when full; caller keeps the word in its holding stage
  always_ff @(posedge clk) begin
    if (push && !full) begin
      mem[wr_ptr] <= din;
    end
  end

  // Pointers and occupancy; flush wins over any traffic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push && !full) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop && !empty) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
    end
  end

  assign dout  = mem[rd_ptr];
  assign full  = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);

endmodule // urx_fifo

`default_nettype wire

/* urx_top.sv */
`timescale 1ns/10ps
`default_nettype none

// Operation
// (R1) Ready flag shows FIFO holds data
// (R2) Buffer read returns and pops oldest entry
// (R3) Full flag when all slots occupied
// (R4) Mode one bit six picks interrupt source
// (R5) Entries carry parity, framing, break flags
// (R6) Character mode: flags from head entry
// (R7) Block mode: flags accumulate until reset-error
// (R8) Status read leaves FIFO untouched
// (R9) Full FIFO: character waits in holding stage
// (R10) New start drops waiting character, sets overrun
// (R11) Flow control negates RTS on full start
// (R12) Flow control reasserts RTS when slot frees
// (R13) Host asserts RTS manually first time
// (R14) Disabled receiver keeps FIFO, accepts nothing
// (R15) Disable discards partial and waiting characters
// (R16) Receiver reset flushes, clears flags, disables
// (R17) Mode two bits pick channel mode
// (R18) Echo retransmits line, blocks host writes
// (R19) Local loopback feeds transmitter to receiver
// (R20) Remote loopback echoes, blocks both host paths
// (R21) Mode one bits 4:3 eleven: multidrop
// (R22) Multidrop tag replaces parity, no checking
// (R23) Multidrop disabled: keep address characters only
// (R24) Overrun sticky until reset-error or reset
module urx_top
  import urx_pkg::*;
#(
  parameter int FIFO_DEPTH = URX_FIFO_DEPTH_DEF,
  parameter int BIT_CLKS   = URX_BIT_CLKS_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rxd,
  output logic             txd,
  // Transmitter side
  input  wire logic        tx_serial,
  output logic             tx_wr_block,
  // Flow control and request
  output logic             output_line_zero_b,
  output logic             rx_irq
);

  localparam int HALF_CLKS = BIT_CLKS / 2;
  localparam int CW        = $clog2(BIT_CLKS + 1);
  localparam int FCW       = $clog2(FIFO_DEPTH) + 1;

  // Address match shared by read mux and write strobes
  function automatic logic urx_hit(input logic [7:0] a, input logic [7:0] off);
    return (a[7:2] == off[7:2]);
  endfunction

  logic [7:0]          mode_one;
  logic [7:0]          mode_two;
  logic                rx_en;
  logic                ovr;
  logic [2:0]          blk_err;
  urx_chan_mode_t      chan_mode;
  urx_rx_state_t       state;
  logic [CW-1:0]       cnt;
  logic [2:0]          idx;
  logic [7:0]          shreg;
  logic                tag;
  logic                rx_prev;
  logic                rx_line;
  logic                char_done;
  logic [URX_ENT_W-1:0] char_word;
  logic                char_keep;
  logic                hold_valid;
  logic [URX_ENT_W-1:0] hold_word;
  logic                start_ok;
  logic                push;
  logic                pop;
  logic                fifo_full;
  logic                fifo_empty;
  logic [URX_ENT_W-1:0] head;
  logic [FCW-1:0]      fifo_count;
  logic [7:0]          st_word;
  logic                acc;
  logic                acc_wr;
  logic                acc_rd;
  logic                cmd_wr;
  logic                rst_rx_cmd;
  logic                rst_err_cmd;
  logic                dis_cmd;
  logic                oc_wr;
  logic                mapped;
  logic                multidrop;
  logic                par_bit_en;
  logic                flow;
  logic                stop_sample;
  logic                brk_now;
  logic                par_err_now;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign acc    = psel && penable && pready;
  assign acc_wr = acc && pwrite;
  assign acc_rd = acc && !pwrite;
  assign mapped = urx_hit(paddr, URX_ADDR_MODE_ONE) || urx_hit(paddr, URX_ADDR_MODE_TWO) ||
                  urx_hit(paddr, URX_ADDR_STATUS) || urx_hit(paddr, URX_ADDR_COMMAND) ||
                  urx_hit(paddr, URX_ADDR_RX_BUF) || urx_hit(paddr, URX_ADDR_OUT_CTRL);
  assign cmd_wr      = acc_wr && urx_hit(paddr, URX_ADDR_COMMAND);
  assign rst_rx_cmd  = cmd_wr && (pwdata[7:4] == URX_CMD_RST_RX);
  assign rst_err_cmd = cmd_wr && (pwdata[7:4] == URX_CMD_RST_ERR);
  assign dis_cmd     = cmd_wr && (pwdata[1:0] == URX_RX_DISABLE);
  assign oc_wr       = acc_wr && urx_hit(paddr, URX_ADDR_OUT_CTRL);
  // Only a buffer read with data waiting pops an entry
  assign pop = acc_rd && urx_hit(paddr, URX_ADDR_RX_BUF) && !fifo_empty; // [R2] [R8]

  // Zero-wait slave: pready rises for the access phase only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= '0;
        if (urx_hit(paddr, URX_ADDR_MODE_ONE)) prdata[7:0] <= mode_one;
        if (urx_hit(paddr, URX_ADDR_MODE_TWO)) prdata[7:0] <= mode_two;
        if (urx_hit(paddr, URX_ADDR_STATUS))   prdata[7:0] <= st_word;
        if (urx_hit(paddr, URX_ADDR_RX_BUF) && !fifo_empty) begin
          prdata[7:0] <= head[7:0]; // [R2]
        end
      end
    end
  end

  // Mode registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_one <= URX_MODE_ONE_RST;
      mode_two <= URX_MODE_TWO_RST;
    end else begin
      if (acc_wr && urx_hit(paddr, URX_ADDR_MODE_ONE)) mode_one <= pwdata[7:0];
      if (acc_wr && urx_hit(paddr, URX_ADDR_MODE_TWO)) mode_two <= pwdata[7:0];
    end
  end

  assign chan_mode  = urx_chan_mode_t'(mode_two[7:6]); // [R17]
  assign multidrop  = (mode_one[4:3] == URX_PAR_MDROP); // [R21]
  assign par_bit_en = (mode_one[4:3] != URX_PAR_NONE);
  assign flow       = mode_one[URX_M1_FLOW];

  // Receiver enable; reset command leaves it off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_en <= 1'b0;
    end else if (rst_rx_cmd || dis_cmd) begin
      rx_en <= 1'b0; // [R16] [R14]
    end else if (cmd_wr && pwdata[1:0] == URX_RX_ENABLE) begin
      rx_en <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  assign rx_line     = (chan_mode == URX_LOCAL) ? tx_serial : rxd; // [R19]
  assign start_ok    = (state == URX_START) && (cnt == CW'(HALF_CLKS - 1)) && !rx_line;
  assign stop_sample = (state == URX_STOP) && (cnt == CW'(BIT_CLKS - 1));
  assign brk_now     = !rx_line && (shreg == 8'h00) && !(par_bit_en && tag);
  // Multidrop carries the tag in place of a parity result
  assign par_err_now = multidrop ? tag :                                  // [R22]
                       (mode_one[4:3] == URX_PAR_WITH) ?
                         ((^shreg) ^ tag ^ mode_one[URX_M1_PAR_ODD]) :
                       (mode_one[4:3] == URX_PAR_FORCE) ?
                         (tag != mode_one[URX_M1_PAR_ODD]) : 1'b0;

  // Framing machine; multidrop keeps listening while disabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= URX_IDLE;
      cnt     <= '0;
      idx     <= '0;
      shreg   <= '0;
      tag     <= 1'b0;
      rx_prev <= 1'b1;
    end else if (rst_rx_cmd || (dis_cmd && !multidrop)) begin
      state   <= URX_IDLE; // [R15]
      cnt     <= '0;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_line;
      unique case (state)
        URX_IDLE: begin
          cnt <= '0;
          if ((rx_en || multidrop) && rx_prev && !rx_line) state <= URX_START; // [R14]
        end
        URX_START: begin
          cnt <= cnt + 1'b1;
          if (cnt == CW'(HALF_CLKS - 1)) begin
            cnt   <= '0;
            idx   <= '0;
            shreg <= '0;
            tag   <= 1'b0;
            state <= rx_line ? URX_IDLE : URX_DATA;
          end
        end
        URX_DATA: begin
          cnt <= cnt + 1'b1;
          if (cnt == CW'(BIT_CLKS - 1)) begin
            cnt        <= '0;
            shreg[idx] <= rx_line;
            idx        <= idx + 1'b1;
            if (idx == {1'b1, mode_one[1:0]}) state <= par_bit_en ? URX_PARB : URX_STOP;
          end
        end
        URX_PARB: begin
          cnt <= cnt + 1'b1;
          if (cnt == CW'(BIT_CLKS - 1)) begin
            cnt   <= '0;
            tag   <= rx_line;
            state <= URX_STOP;
          end
        end
        URX_STOP: begin
          cnt <= cnt + 1'b1;
          if (stop_sample) begin
            cnt   <= '0;
            state <= rx_line ? URX_IDLE : (brk_now ? URX_BRKW : URX_START);
          end
        end
        URX_BRKW: begin
          // Line must stay high half a bit before hunting again
          cnt <= rx_line ? cnt + 1'b1 : '0;
          if (rx_line && cnt == CW'(HALF_CLKS - 1)) state <= URX_IDLE;
        end
        default: state <= URX_IDLE;
      endcase
    end
  end

  // Completed character with its per-entry flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      char_done <= 1'b0;
      char_word <= '0;
      char_keep <= 1'b0;
    end else begin
      char_done <= stop_sample && !rst_rx_cmd;
      char_word <= {brk_now, !rx_line && !brk_now, par_err_now, shreg}; // [R5]
      // Remote loopback keeps nothing for the host
      char_keep <= (chan_mode != URX_REMOTE) && (rx_en || (multidrop && tag)); // [R23] [R20]
    end
  end

  // ----------------------------------------------------------------
  // Holding stage and FIFO
  // ----------------------------------------------------------------
  assign push = hold_valid && !fifo_full;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_valid <= 1'b0;
      hold_word  <= '0;
    end else if (rst_rx_cmd || dis_cmd) begin
      hold_valid <= 1'b0; // [R15]
    end else if (char_done && char_keep) begin
      hold_valid <= 1'b1;
      hold_word  <= char_word;
    end else if (start_ok && hold_valid) begin
      hold_valid <= 1'b0; // [R10]
    end else if (push) begin
      hold_valid <= 1'b0; // [R9]
    end
  end

  urx_fifo #(
    .WIDTH (URX_ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .push  (push),
    .pop   (pop),
    .flush (rst_rx_cmd), // [R16]
    .din   (hold_word),
    .dout  (head),
    .full  (fifo_full),
    .empty (fifo_empty),
    .count (fifo_count)
  );

  // ----------------------------------------------------------------
  // Error reporting
  // ----------------------------------------------------------------
  // Sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovr     <= 1'b0;
      blk_err <= '0;
    end else begin
      ovr <= ((rst_err_cmd || rst_rx_cmd) ? 1'b0 : ovr) ||
             (start_ok && hold_valid && fifo_full); // [R24] [R10]
      blk_err <= ((rst_err_cmd || rst_rx_cmd) ? 3'h0 : blk_err) |
                 (push ? hold_word[URX_ENT_BRK:URX_ENT_PAR] : 3'h0); // [R7]
    end
  end

  // Status word; only the buffer read pops
  always_comb begin
    st_word              = '0;
    st_word[URX_ST_RDY]  = !fifo_empty; // [R1]
    st_word[URX_ST_FULL] = fifo_full;   // [R3]
    st_word[URX_ST_OVR]  = ovr;
    if (mode_one[URX_M1_BLOCK]) begin
      st_word[URX_ST_BRK:URX_ST_PAR] = blk_err; // [R7]
    end else if (!fifo_empty) begin
      st_word[URX_ST_BRK:URX_ST_PAR] = head[URX_ENT_BRK:URX_ENT_PAR]; // [R6]
    end
  end

  // ----------------------------------------------------------------
  // Output lines
  // ----------------------------------------------------------------
  // Request line follows the selected FIFO condition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= rst_rx_cmd ? 1'b0 :
                (mode_one[URX_M1_IRQ_SEL] ? fifo_full : !fifo_empty); // [R4] [R16]
    end
  end

  // RTS: host sets it once, then the receiver steers it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      output_line_zero_b <= 1'b1;
    end else if (rst_rx_cmd) begin
      output_line_zero_b <= 1'b1; // [R16]
    end else if (oc_wr && pwdata[URX_OC_RTS_ON]) begin
      output_line_zero_b <= 1'b0; // [R13]
    end else if (oc_wr && pwdata[URX_OC_RTS_OFF]) begin
      output_line_zero_b <= 1'b1;
    end else if (flow && pop) begin
      output_line_zero_b <= 1'b0; // [R12]
    end else if (flow && start_ok && fifo_full) begin
      output_line_zero_b <= 1'b1; // [R11]
    end
  end

  // Line and transmitter gating by channel mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txd         <= 1'b1;
      tx_wr_block <= 1'b0;
    end else begin
      unique case (chan_mode)
        URX_NORMAL: txd <= tx_serial;
        URX_ECHO:   txd <= rxd;  // [R18]
        URX_LOCAL:  txd <= 1'b1; // [R19]
        URX_REMOTE: txd <= rxd;  // [R20]
      endcase
      tx_wr_block <= (chan_mode == URX_ECHO) || (chan_mode == URX_REMOTE); // [R18] [R20]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rdy;
    @(posedge clk) disable iff (!rst_b) push && !rst_rx_cmd |=> st_word[URX_ST_RDY];
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready flag missing after push"); // [R1]

  property p_pop;
    @(posedge clk) disable iff (!rst_b)
      pop && fifo_count == FCW'(1) && !push |=> fifo_empty;
  endproperty
  a_pop: assert property (p_pop) else $error("last entry not removed by read"); // [R2]

  property p_full;
    @(posedge clk) disable iff (!rst_b)
      st_word[URX_ST_FULL] == (fifo_count == FCW'(FIFO_DEPTH));
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong"); // [R3]

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
      !rst_rx_cmd |=> rx_irq == $past(mode_one[URX_M1_IRQ_SEL] ? fifo_full : !fifo_empty);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt source wrong"); // [R4]

  property p_ovr;
    @(posedge clk) disable iff (!rst_b)
      start_ok && hold_valid && fifo_full && !rst_rx_cmd && !dis_cmd |=> ovr && !hold_valid ##1 ovr;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged"); // [R10]

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      hold_valid && fifo_full && !pop && !start_ok && !rst_rx_cmd && !dis_cmd |=> hold_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("waiting character lost"); // [R9]

  property p_rts_neg;
    @(posedge clk) disable iff (!rst_b)
      flow && start_ok && fifo_full && !pop && !oc_wr && !rst_rx_cmd |=> output_line_zero_b;
  endproperty
  a_rts_neg: assert property (p_rts_neg) else $error("RTS not negated"); // [R11]

  property p_rts_re;
    @(posedge clk) disable iff (!rst_b)
      flow && pop && !oc_wr && !rst_rx_cmd |=> !output_line_zero_b;
  endproperty
  a_rts_re: assert property (p_rts_re) else $error("RTS not reasserted"); // [R12]

  property p_local;
    @(posedge clk) disable iff (!rst_b) chan_mode == URX_LOCAL |=> txd;
  endproperty
  a_local: assert property (p_local) else $error("pin not at mark"); // [R19]

  property p_rx_rst;
    @(posedge clk) disable iff (!rst_b)
      rst_rx_cmd |=> fifo_empty && !ovr && !rx_en && !hold_valid && output_line_zero_b;
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("receiver reset incomplete"); // [R16]

  c_overrun: cover property (@(posedge clk) disable iff (!rst_b) start_ok && hold_valid);
  c_fill:    cover property (@(posedge clk) disable iff (!rst_b) fifo_full ##1 pop);
  c_break:   cover property (@(posedge clk) disable iff (!rst_b) push && hold_word[URX_ENT_BRK]);

endmodule // urx_top

`default_nettype wire

/* urx_line_drv.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Remote serial transmitter on the receive line
// ----------------------------------------------------------------
module urx_line_drv #(
  parameter int BIT_CLKS = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Frame request: bit 9 stop level, bit 8 parity or tag, 7:0 data
  input  wire logic       go,
  input  wire logic [9:0] frame,
  // Line
  output logic            rxd,
  output logic            busy
);
  logic [10:0] sh;
  int          n;
  int          c;

  // Start bit, data LSB first, parity slot, stop; line idles high as if pulled up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxd <= 1'h1;
      busy <= 1'h0;
      sh <= 11'h7FF;
      n <= 0;
      c <= 0;
    end else if (busy) begin
      if (c == 1) begin
        c <= BIT_CLKS;
        n <= n - 1;
        sh <= {1'h1, sh[10:1]};
        rxd <= sh[1];
        busy <= (n != 1);
      end else begin
        c <= c - 1;
      end
    end else if (go) begin
      sh <= {frame, 1'h0};
      rxd <= 1'h0;
      n <= 11;
      c <= BIT_CLKS;
      busy <= 1'h1;
    end
  end
endmodule // urx_line_drv

`default_nettype wire

/* uart_rx_fifo_status_loopback_test.sv */
`timescale 1ns/10ps
`default_nettype none

module uart_rx_fifo_status_loopback_test
  import urx_pkg::*;
;
  logic        clk, rst_b, psel, penable, pwrite, tx_serial, go, err;
  logic        pready, pslverr, rxd, txd, tx_wr_block, rts_b, rx_irq, busy;
  logic [7:0]  paddr;
  logic [9:0]  frame;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [7:0]  q[$];
  int          bad_count, n_checks, cyc;

  urx_top #(.FIFO_DEPTH(8), .BIT_CLKS(4)) i_dut (.clk(clk), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_serial(tx_serial),
    .tx_wr_block(tx_wr_block), .output_line_zero_b(rts_b), .rx_irq(rx_irq));
  urx_line_drv #(.BIT_CLKS(4)) i_line (.clk(clk), .rst_b(rst_b), .go(go), .frame(frame),
    .rxd(rxd), .busy(busy));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Status word: error bits {break, framing, parity}, overrun, full, ready
  function automatic logic [31:0] st(input int n, input logic o, input logic [2:0] e);
    return {24'h0, e, o, 2'h0, n == 8, n != 0};
  endfunction

  // Even parity frame, optionally with the parity bit turned round
  function automatic logic [9:0] fr(input logic [7:0] d, input logic bad);
    return {1'h1, ^d ^ bad, d};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Two idle edges at the end keep psel from being driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    repeat (2) @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 8'h00);
    chk(rd, exp);
  endtask

  task automatic send(input logic [9:0] f);
    go <= 1'h1;
    frame <= f;
    @(posedge clk);
    go <= 1'h0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, go, err} = 6'h00;
    {paddr, pwdata, frame, rd, cyc, bad_count, n_checks} = '0;
    tx_serial = 1'h1;
    seed = 32'hAA3EA453;
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    chk(rts_b, 1'h1);
    apb(1'h1, URX_ADDR_MODE_ONE, 8'h03);
    apb(1'h1, URX_ADDR_COMMAND, 8'h01);
    seed = lfsr(seed);
    send(fr(seed[7:0], 1'h0));
    rdc(URX_ADDR_STATUS, st(1, 0, 0));
    rdc(URX_ADDR_STATUS, st(1, 0, 0));
    rdc(URX_ADDR_RX_BUF, {24'h0, seed[7:0]});
    rdc(URX_ADDR_STATUS, st(0, 0, 0));
    $display("test 1 done");
    // Fill past the top with flow control and the full-flag request
    apb(1'h1, URX_ADDR_MODE_ONE, 8'hC3);
    apb(1'h1, URX_ADDR_OUT_CTRL, 8'h01);
    chk(rts_b, 1'h0);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      q.push_back(i == 0 ? 8'hFF : seed[7:0]);
      send(fr(q[i], 1'h0));
    end
    chk(rts_b, 1'h1);
    chk(rx_irq, 1'h1);
    rdc(URX_ADDR_STATUS, st(8, 0, 0));
    rdc(URX_ADDR_RX_BUF, q.pop_front());
    chk(rts_b, 1'h0);
    rdc(URX_ADDR_STATUS, st(8, 0, 0));
    send(fr(8'h5A, 1'h0));
    send(fr(8'hA5, 1'h0));
    rdc(URX_ADDR_STATUS, st(8, 1, 0));
    q.push_back(8'hA5);
    while (q.size() > 1) rdc(URX_ADDR_RX_BUF, q.pop_front());
    rdc(URX_ADDR_STATUS, st(1, 1, 0));
    rdc(URX_ADDR_RX_BUF, q.pop_front());
    apb(1'h1, URX_ADDR_COMMAND, 8'h40);
    rdc(URX_ADDR_STATUS, st(0, 0, 0));
    $display("test 2 done");
    // Parity error, break, clean character: block then character mode
    apb(1'h1, URX_ADDR_MODE_ONE, 8'h23);
    send(fr(8'hC3, 1'h1));
    send(10'h000);
    send(fr(seed[7:0], 1'h0));
    rdc(URX_ADDR_STATUS, st(3, 0, 3'h5));
    apb(1'h1, URX_ADDR_MODE_ONE, 8'h03);
    rdc(URX_ADDR_STATUS, st(3, 0, 3'h1));
    rdc(URX_ADDR_RX_BUF, 32'hC3);
    rdc(URX_ADDR_STATUS, st(2, 0, 3'h4));
    rdc(URX_ADDR_RX_BUF, 32'h00);
    rdc(URX_ADDR_STATUS, st(1, 0, 3'h0));
    rdc(URX_ADDR_RX_BUF, {24'h0, seed[7:0]});
    $display("test 3 done");
    // Disable keeps stored data; receiver reset flushes and stays off
    send(fr(8'h11, 1'h0));
    apb(1'h1, URX_ADDR_COMMAND, 8'h02);
    send(fr(8'h22, 1'h0));
    rdc(URX_ADDR_STATUS, st(1, 0, 0));
    rdc(URX_ADDR_RX_BUF, 32'h11);
    apb(1'h1, URX_ADDR_COMMAND, 8'h01);
    send(fr(8'h33, 1'h0));
    apb(1'h1, URX_ADDR_COMMAND, 8'h20);
    chk(rx_irq, 1'h0);
    send(fr(8'h44, 1'h0));
    rdc(URX_ADDR_STATUS, st(0, 0, 0));
    $display("test 4 done");
    // Multidrop: address kept while disabled, tag in the parity slot
    apb(1'h1, URX_ADDR_MODE_ONE, 8'h1B);
    send({2'h3, 8'h5A});
    send({2'h2, 8'h66});
    rdc(URX_ADDR_STATUS, st(1, 0, 3'h1));
    rdc(URX_ADDR_RX_BUF, 32'h5A);
    apb(1'h1, URX_ADDR_COMMAND, 8'h01);
    send({2'h2, 8'h01});
    rdc(URX_ADDR_STATUS, st(1, 0, 3'h0));
    rdc(URX_ADDR_RX_BUF, 32'h01);
    apb(1'h0, 8'h18, 8'h00);
    chk(err, 1'h1);
    $display("test 5 done");
    // Channel modes, transmitter idling low so each path shows
    tx_serial <= 1'h0;
    for (int m = 3; m >= 0; m--) begin
      apb(1'h1, URX_ADDR_MODE_TWO, {m[1:0], 6'h00});
      chk({txd, tx_wr_block}, {m != 0, m[0]});
    end
    $display("test 6 done");
    wrap_up();
  end
endmodule // uart_rx_fifo_status_loopback_test

`default_nettype wire
